// File: verilog/rtcst_pkg.sv
// Purpose: Shared constants for the clock status, test and adjust register block.
// Assumes: Registers sit in one aligned 32-bit word each; byte address is four times the index.
// Notes: Only the low four data bits of the device registers carry meaning.
`default_nettype none
package rtcst_pkg;
    // ****************************************************************
    // Bus geometry and answers
    // ****************************************************************
    localparam int RTCST_ADDR_W = 8;
    localparam int RTCST_DATA_W = 32;
    localparam int RTCST_IDX_W = 6;
    localparam logic [1:0] RTCST_RESP_OKAY = 2'h0;
    localparam logic [1:0] RTCST_RESP_SLVERR = 2'h2;
    localparam logic [31:0] RTCST_RD_ZERO = 32'h0;
    // ****************************************************************
    // Register indices (byte address = index * 4)
    // ****************************************************************
    localparam logic [5:0] RTCST_IDX_ADJUST = 6'h01;
    localparam logic [5:0] RTCST_IDX_STATUS = 6'h0E;
    localparam logic [5:0] RTCST_IDX_TESTDIV = 6'h0F;
    localparam logic [5:0] RTCST_IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] RTCST_IDX_IRQ_MASK = 6'h11;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RTCST_BIT_OSC = 0;
    localparam int RTCST_BIT_ALARM = 1;
    localparam int RTCST_BIT_PERIODIC = 2;
    localparam int RTCST_BIT_BUSY = 3;
    localparam int RTCST_BIT_ROUND = 0;
    localparam int RTCST_BIT_DIV_RST = 1;
    localparam int RTCST_BIT_TEST_B = 2;
    localparam int RTCST_BIT_TEST_A = 3;
    localparam int RTCST_IRQ_W = 4;
    localparam int RTCST_IRQ_OSC = 0;
    localparam int RTCST_IRQ_ALARM = 1;
    localparam int RTCST_IRQ_PERIODIC = 2;
    localparam int RTCST_IRQ_BUSY_DONE = 3;
    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic RTCST_TEST_RST = 1'b1;
    localparam logic [3:0] RTCST_IRQ_RST = 4'h0;
    localparam int RTCST_BUSY_TIME_NS = 122100;
    localparam int RTCST_CLK_PERIOD_NS = 100;
    localparam int RTCST_BUSY_CYCLES = RTCST_BUSY_TIME_NS / RTCST_CLK_PERIOD_NS;
    localparam int RTCST_BUSY_W = 11;
    localparam logic [10:0] RTCST_BUSY_LOAD = 11'(RTCST_BUSY_CYCLES);
    localparam logic [10:0] RTCST_BUSY_ZERO = 11'h000;
    localparam logic [10:0] RTCST_BUSY_ONE = 11'h001;
endpackage
`default_nettype wire

// File: verilog/rtcst_regs.sv
// Purpose: Status, test/divider-reset and second-adjust registers of a real-time clock.
// Assumes: AXI4-Lite slave on aclk; counter, alarm and periodic logic sit outside.
`timescale 1ns/1ns
`default_nettype none
module rtcst_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rtcst_pkg::RTCST_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rtcst_pkg::RTCST_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [rtcst_pkg::RTCST_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [rtcst_pkg::RTCST_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    input wire logic osc_running,
    input wire logic chip_enable,
    input wire logic bank_sel,
    input wire logic alarm_irq_enable,
    input wire logic alarm_match,
    input wire logic periodic_active,
    input wire logic periodic_level_mode,
    input wire logic counter_carry,
    input wire logic seconds_ge_30,
    output logic interrupt_out_n,
    output logic timer_source_msb_clear,
    output logic divider_reset,
    output logic seconds_clear,
    output logic minute_increment,
    output logic factory_test_bit_a,
    output logic factory_test_bit_b,
    output logic counter_busy_flag
);
    import rtcst_pkg::*;
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [RTCST_IDX_W-1:0] aw_idx;
    logic [3:0] w_nib;
    logic w_lane0;
    logic [1:0] in_meta;
    logic [1:0] in_sync;
    logic osc_stop_flag;
    logic osc_stopped_d;
    logic alarm_match_flag;
    logic alarm_hit_d;
    logic periodic_irq_flag;
    logic periodic_d;
    logic busy_d;
    logic [RTCST_BUSY_W-1:0] busy_cnt;
    logic [RTCST_IRQ_W-1:0] irq_status;
    logic [RTCST_IRQ_W-1:0] irq_mask;
    logic [31:0] busy_len;
    logic osc_sync;
    logic ce_sync;
    logic do_write;
    logic wr_en;
    logic wr_status;
    logic wr_testdiv;
    logic wr_adjust;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_mapped;
    logic [RTCST_IDX_W-1:0] ar_idx;
    logic rd_mapped;
    logic [3:0] status_word;
    logic [3:0] rd_nib;
    logic alarm_hit;
    logic alarm_set;
    logic periodic_set;
    logic start_div_rst;
    logic start_adjust;
    logic next_osc_stop_flag;
    logic next_alarm_match_flag;
    logic next_periodic_irq_flag;
    logic [RTCST_BUSY_W-1:0] next_busy_cnt;
    logic [RTCST_IRQ_W-1:0] irq_event;
    logic [RTCST_IRQ_W-1:0] next_irq_status;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Address and data are held separately; the write fires once both are in.
    assign awready = !aw_held;
    assign wready = !w_held;
    assign arready = !rvalid;
    assign osc_sync = in_sync[0];
    assign ce_sync = in_sync[1];
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_en = do_write && w_lane0;
    // Status and test/divider decode ignore the bank; adjust needs bank 1.
    assign wr_status = wr_en && (aw_idx == RTCST_IDX_STATUS);
    assign wr_testdiv = wr_en && (aw_idx == RTCST_IDX_TESTDIV);
    assign wr_adjust = wr_en && bank_sel && (aw_idx == RTCST_IDX_ADJUST);
    assign wr_irq_status = wr_en && (aw_idx == RTCST_IDX_IRQ_STATUS);
    assign wr_irq_mask = wr_en && (aw_idx == RTCST_IDX_IRQ_MASK);
    assign wr_mapped = (aw_idx == RTCST_IDX_STATUS) || (aw_idx == RTCST_IDX_TESTDIV)
        || (bank_sel && (aw_idx == RTCST_IDX_ADJUST))
        || (aw_idx == RTCST_IDX_IRQ_STATUS) || (aw_idx == RTCST_IDX_IRQ_MASK);
    assign ar_idx = araddr[RTCST_ADDR_W-1:2];
    assign rd_mapped = (ar_idx == RTCST_IDX_STATUS) || (ar_idx == RTCST_IDX_TESTDIV)
        || (bank_sel && (ar_idx == RTCST_IDX_ADJUST))
        || (ar_idx == RTCST_IDX_IRQ_STATUS) || (ar_idx == RTCST_IDX_IRQ_MASK);
    // Write-only registers and unmapped words read as zero.
    assign status_word = {counter_busy_flag, periodic_irq_flag, alarm_match_flag, osc_stop_flag};
    assign rd_nib = (ar_idx == RTCST_IDX_STATUS) ? status_word
        : (ar_idx == RTCST_IDX_IRQ_STATUS) ? irq_status
        : (ar_idx == RTCST_IDX_IRQ_MASK) ? irq_mask
        : 4'h0;

    // ****************************************************************
    // Flag next values
    // ****************************************************************
    // A hardware set always wins over a software clear in the same cycle.
    assign next_osc_stop_flag = !osc_sync
        || (osc_stop_flag && !(wr_status && !w_nib[RTCST_BIT_OSC]));
    assign alarm_hit = alarm_irq_enable && alarm_match;
    assign alarm_set = alarm_hit && !alarm_hit_d;
    assign next_alarm_match_flag = alarm_irq_enable
        && (alarm_set || (alarm_match_flag && !(wr_status && !w_nib[RTCST_BIT_ALARM])));
    assign periodic_set = periodic_active && !periodic_d;
    assign next_periodic_irq_flag = !periodic_level_mode ? periodic_active
        : (periodic_set
        || (periodic_irq_flag && !(wr_status && !w_nib[RTCST_BIT_PERIODIC])));
    assign start_div_rst = wr_testdiv && w_nib[RTCST_BIT_DIV_RST];
    assign start_adjust = wr_adjust && w_nib[RTCST_BIT_ROUND];
    assign next_busy_cnt = (start_div_rst || start_adjust) ? RTCST_BUSY_LOAD
        : (busy_cnt != RTCST_BUSY_ZERO) ? busy_cnt - RTCST_BUSY_ONE
        : RTCST_BUSY_ZERO;
    assign irq_event[RTCST_IRQ_OSC] = !osc_sync && !osc_stopped_d;
    assign irq_event[RTCST_IRQ_ALARM] = alarm_set;
    assign irq_event[RTCST_IRQ_PERIODIC] = periodic_set;
    assign irq_event[RTCST_IRQ_BUSY_DONE] = busy_d && !counter_busy_flag;
    assign next_irq_status = irq_event
        | (irq_status & ~(wr_irq_status ? w_nib : RTCST_IRQ_RST));

    // ****************************************************************
    // Write channel
    // ****************************************************************
    // Captures address and data, then answers once both have been taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= '0;
            w_nib <= 4'h0;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RTCST_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_idx <= awaddr[RTCST_ADDR_W-1:2];
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_nib <= wdata[3:0];
                w_lane0 <= wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? RTCST_RESP_OKAY : RTCST_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= RTCST_RD_ZERO;
            rresp <= RTCST_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {28'h0, rd_nib};
            rresp <= rd_mapped ? RTCST_RESP_OKAY : RTCST_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Status flags and pulses
    // ****************************************************************
    // Oscillator and chip enable come from outside and pass two flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_meta <= 2'h3;
            in_sync <= 2'h3;
        end else begin
            in_meta <= {chip_enable, osc_running};
            in_sync <= in_meta;
        end
    end

    // Sticky flags, their edge history and the outgoing pulses.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_stop_flag <= 1'b0;
            osc_stopped_d <= 1'b0;
            alarm_match_flag <= 1'b0;
            alarm_hit_d <= 1'b0;
            periodic_irq_flag <= 1'b0;
            periodic_d <= 1'b0;
            timer_source_msb_clear <= 1'b0;
            divider_reset <= 1'b0;
            seconds_clear <= 1'b0;
            minute_increment <= 1'b0;
            interrupt_out_n <= 1'b1;
        end else begin
            osc_stop_flag <= next_osc_stop_flag;
            osc_stopped_d <= !osc_sync;
            alarm_match_flag <= next_alarm_match_flag;
            alarm_hit_d <= alarm_hit;
            periodic_irq_flag <= next_periodic_irq_flag;
            periodic_d <= periodic_active;
            timer_source_msb_clear <= !osc_sync && !osc_stopped_d;
            divider_reset <= start_div_rst || start_adjust;
            seconds_clear <= start_adjust;
            minute_increment <= start_adjust && seconds_ge_30;
            interrupt_out_n <= !(next_alarm_match_flag || next_periodic_irq_flag);
        end
    end

    // Busy window from divider reset or adjust, plus live counter carries.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_cnt <= RTCST_BUSY_ZERO;
            counter_busy_flag <= 1'b0;
            busy_d <= 1'b0;
        end else begin
            busy_cnt <= next_busy_cnt;
            counter_busy_flag <= counter_carry || (busy_cnt != RTCST_BUSY_ZERO);
            busy_d <= counter_busy_flag;
        end
    end

    // Test bits take written values; chip enable low forces normal mode.
    always_ff @(posedge aclk) begin
        if (!aresetn || !ce_sync) begin
            factory_test_bit_a <= RTCST_TEST_RST;
            factory_test_bit_b <= RTCST_TEST_RST;
        end else if (wr_testdiv) begin
            factory_test_bit_a <= w_nib[RTCST_BIT_TEST_A];
            factory_test_bit_b <= w_nib[RTCST_BIT_TEST_B];
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // Events latch into status; write one clears; mask gates the level output.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= RTCST_IRQ_RST;
            irq_mask <= RTCST_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_irq_mask) begin
                irq_mask <= w_nib;
            end
            irq <= |(next_irq_status & (wr_irq_mask ? w_nib : irq_mask));
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Counts busy cycles since the last start while no carry is present.
    always_ff @(posedge aclk) begin
        if (!aresetn || counter_carry || start_div_rst || start_adjust) begin
            busy_len <= 32'h0;
        end else if (counter_busy_flag) begin
            busy_len <= busy_len + 32'h1;
        end else begin
            busy_len <= 32'h0;
        end
    end
    property p_osc_sticky;
        @(posedge aclk) disable iff (!aresetn)
        osc_stop_flag && !(wr_status && !w_nib[RTCST_BIT_OSC]) |=> osc_stop_flag;
    endproperty
    a_osc_sticky: assert property (p_osc_sticky) else $error("stop flag lost");
    property p_tmsb;
        @(posedge aclk) disable iff (!aresetn)
        $fell(osc_sync) |=> timer_source_msb_clear ##1 osc_stop_flag;
    endproperty
    a_tmsb: assert property (p_tmsb) else $error("no timer msb clear");
    property p_alarm_off;
        @(posedge aclk) disable iff (!aresetn)
        !alarm_irq_enable |=> !alarm_match_flag;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm flag while off");
    property p_alarm_set;
        @(posedge aclk) disable iff (!aresetn)
        alarm_irq_enable && alarm_match && !alarm_hit_d |=> alarm_match_flag && !interrupt_out_n;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm flag missed");
    property p_pulse_mode;
        @(posedge aclk) disable iff (!aresetn)
        !periodic_level_mode |=> periodic_irq_flag == $past(periodic_active);
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("periodic flag wrong");
    property p_busy_start;
        @(posedge aclk) disable iff (!aresetn)
        start_div_rst |=> divider_reset ##1 counter_busy_flag [*8];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");
    property p_busy_max;
        @(posedge aclk) disable iff (!aresetn)
        busy_len <= RTCST_BUSY_CYCLES;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_test_force;
        @(posedge aclk) disable iff (!aresetn)
        !ce_sync |=> factory_test_bit_a && factory_test_bit_b;
    endproperty
    a_test_force: assert property (p_test_force) else $error("test bits not forced");
    property p_rd_zero;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && (ar_idx == RTCST_IDX_TESTDIV) |=> rvalid && rdata == RTCST_RD_ZERO;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("write-only read nonzero");
    property p_interrupt_out_n;
        @(posedge aclk) disable iff (!aresetn)
        !alarm_match_flag && !periodic_irq_flag |-> interrupt_out_n;
    endproperty
    a_interrupt_out_n: assert property (p_interrupt_out_n) else $error("interrupt low with no flag");
endmodule
`default_nettype wire

// File: testbench/rtcst_counter_model.sv
// Purpose: Behavioural model of the time counters beside the status register block.
// Assumes: One tick advances the seconds digit and marks a carry for that cycle.
// Notes: Minutes only count on the increment pulse from the block.
`timescale 1ns/1ns
`default_nettype none
module rtcst_counter_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic seconds_clear,
    input wire logic minute_increment,
    output logic counter_carry,
    output logic seconds_ge_30,
    output logic [5:0] seconds,
    output logic [7:0] minutes
);
    // ****************************************************************
    // Seconds and minutes digits
    // ****************************************************************
    // The clear from the block wins over a tick in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seconds <= 6'h00;
            minutes <= 8'h00;
        end else begin
            if (seconds_clear) begin
                seconds <= 6'h00;
            end else if (tick) begin
                seconds <= (seconds == 6'h3B) ? 6'h00 : seconds + 6'h01;
            end
            if (minute_increment) begin
                minutes <= minutes + 8'h01;
            end
        end
    end
    // A carry lasts as long as the tick; the upper half flag drives the adjust choice.
    assign counter_carry = tick;
    assign seconds_ge_30 = (seconds >= 6'h1E);
endmodule
`default_nettype wire

// File: testbench/rtcst_regs_bench.sv
// Purpose: Self-checking bench for the status, test and adjust register block.
// Assumes: AXI4-Lite master tasks; a counter model supplies carries and seconds.
// Notes: Bus answers are queued by the driver and compared by a monitor.
`timescale 1ns/1ns
`default_nettype none
module rtcst_regs_bench;
    import rtcst_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [7:0] A_SA = {RTCST_IDX_ADJUST, 2'h0};
    localparam logic [7:0] A_ST = {RTCST_IDX_STATUS, 2'h0};
    localparam logic [7:0] A_TD = {RTCST_IDX_TESTDIV, 2'h0};
    localparam logic [7:0] A_IS = {RTCST_IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_IM = {RTCST_IDX_IRQ_MASK, 2'h0};
    localparam logic [1:0] OK = RTCST_RESP_OKAY;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq, tick;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, minutes;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [5:0] seconds;
    logic [15:0] lfsr;
    logic osc_running, chip_enable, bank_sel, alarm_irq_enable, alarm_match;
    logic periodic_active, periodic_level_mode, counter_carry, seconds_ge_30;
    logic interrupt_out_n, timer_source_msb_clear, divider_reset, seconds_clear;
    logic minute_increment, factory_test_bit_a, factory_test_bit_b, counter_busy_flag;
    int n_fail, cmp_count, n_msbc, n_div, busy_run, busy_max;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    rtcst_regs i_rtcst_regs (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .irq, .osc_running, .chip_enable,
        .bank_sel, .alarm_irq_enable, .alarm_match, .periodic_active, .periodic_level_mode,
        .counter_carry, .seconds_ge_30, .interrupt_out_n, .timer_source_msb_clear,
        .divider_reset, .seconds_clear, .minute_increment, .factory_test_bit_a,
        .factory_test_bit_b, .counter_busy_flag);
    rtcst_counter_model i_rtcst_counter_model (.aclk, .aresetn, .tick, .seconds_clear,
        .minute_increment, .counter_carry, .seconds_ge_30, .seconds, .minutes);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Clock at 100 ns period.
    always #50 aclk = ~aclk;
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Waits n edges and lands between edges where outputs are settled.
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // Write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] r);
        logic ta, tw, done, ga, gw;
        exp_b.push_back(r);
        lfsr = lfsr_step(lfsr);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {12'h000, lfsr, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        {done, ga, gw} = 3'h0;
        // Waits for the answer; only the watchdog ends a hang.
        while (!done) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid && bready;
            {ga, gw} = {ga || ta, gw || tw};
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        chk({ga, gw}, 2'h3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] d, input logic [1:0] r);
        logic ta, done, ga;
        exp_r.push_back({r, 28'h0000000, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        {done, ga} = 2'h0;
        while (!done) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid && rready;
            ga = ga || ta;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        chk(ga, 1'b1);
    endtask
    // Monitor: compares each bus answer with the oldest note and tracks pulses and busy.
    always @(negedge aclk) begin
        if (bvalid && bready) chk(bresp, exp_b.pop_front());
        if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
        if (timer_source_msb_clear === 1'b1) n_msbc++;
        if (divider_reset === 1'b1) n_div++;
        busy_run = (counter_busy_flag === 1'b1) ? busy_run + 1 : 0;
        if (busy_run > busy_max) busy_max = busy_run;
    end
    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        final_report();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Main sequence.
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick} = 8'h00;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = {8'h00, 8'h00, 6'h00, 32'h0, 4'hF};
        {osc_running, chip_enable, bank_sel, alarm_irq_enable} = 4'hC;
        {alarm_match, periodic_active, periodic_level_mode} = 3'h0;
        {n_fail, cmp_count, n_msbc, n_div, busy_run, busy_max} = '0;
        lfsr = 16'h0047;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wt(3);
        chk({factory_test_bit_a, factory_test_bit_b, counter_busy_flag, interrupt_out_n, irq},
            5'h1A);
        rd(A_TD, 4'h0, OK);
        rd(A_ST, 4'h0, OK);
        @(posedge aclk) osc_running <= 1'b0;
        wt(5);
        @(posedge aclk) osc_running <= 1'b1;
        wt(5);
        chk(n_msbc, 1);
        rd(A_ST, 4'h1, OK);
        rd(A_IS, 4'h1, OK);
        wr(A_IM, 4'h1, OK);
        wt(2);
        chk(irq, 1'b1);
        wr(A_ST, 4'h1, OK);
        rd(A_ST, 4'h1, OK);
        @(posedge aclk) wstrb <= 4'hE;
        wr(A_ST, 4'h0, OK);
        rd(A_ST, 4'h1, OK);
        @(posedge aclk) wstrb <= 4'hF;
        wr(A_ST, 4'h0, OK);
        rd(A_ST, 4'h0, OK);
        wr(A_IS, 4'h1, OK);
        wt(2);
        chk(irq, 1'b0);
        @(posedge aclk) {alarm_irq_enable, alarm_match} <= 2'h3;
        wt(2);
        chk(interrupt_out_n, 1'b0);
        rd(A_ST, 4'h2, OK);
        wr(A_ST, 4'hD, OK);
        wt(1);
        chk(interrupt_out_n, 1'b1);
        rd(A_ST, 4'h0, OK);
        @(posedge aclk) alarm_match <= 1'b0;
        @(posedge aclk) alarm_match <= 1'b1;
        wt(2);
        chk(interrupt_out_n, 1'b0);
        @(posedge aclk) alarm_irq_enable <= 1'b0;
        wt(2);
        chk(interrupt_out_n, 1'b1);
        rd(A_ST, 4'h0, OK);
        @(posedge aclk) {alarm_match, periodic_active} <= 2'h1;
        wt(2);
        chk(interrupt_out_n, 1'b0);
        wr(A_ST, 4'hB, OK);
        rd(A_ST, 4'h4, OK);
        @(posedge aclk) periodic_active <= 1'b0;
        wt(2);
        chk(interrupt_out_n, 1'b1);
        @(posedge aclk) {periodic_level_mode, periodic_active} <= 2'h3;
        @(posedge aclk) periodic_active <= 1'b0;
        rd(A_ST, 4'h4, OK);
        wr(A_ST, 4'hB, OK);
        rd(A_ST, 4'h0, OK);
        busy_max = 0;
        wr(A_TD, 4'h2, OK);
        wt(1);
        chk({n_div, factory_test_bit_a, factory_test_bit_b}, {32'd1, 2'h0});
        wr(A_ST, 4'h0, OK);
        rd(A_ST, 4'h8, OK);
        rd(A_TD, 4'h0, OK);
        @(posedge aclk) chip_enable <= 1'b0;
        wt(4);
        chk({factory_test_bit_a, factory_test_bit_b}, 2'h3);
        @(posedge aclk) chip_enable <= 1'b1;
        wr(A_TD, 4'hC, OK);
        wt(1300);
        chk(n_div, 1);
        chk(busy_max > 0 && busy_max <= RTCST_BUSY_CYCLES, 1'b1);
        busy_max = 0;
        for (int i = 0; i < 35; i++) begin
            @(posedge aclk) tick <= 1'b1;
            @(posedge aclk) tick <= 1'b0;
        end
        wt(2);
        chk(busy_max > 0, 1'b1);
        wr(A_SA, 4'h1, RTCST_RESP_SLVERR);
        @(posedge aclk) bank_sel <= 1'b1;
        rd(A_ST, 4'h0, OK);
        wr(A_SA, 4'h1, OK);
        wt(3);
        chk({minutes, 2'h0, seconds}, 16'h0100);
        rd(A_SA, 4'h0, OK);
        for (int i = 0; i < 5; i++) begin
            @(posedge aclk) tick <= 1'b1;
            @(posedge aclk) tick <= 1'b0;
        end
        wr(A_SA, 4'h1, OK);
        wt(3);
        chk({n_div[7:0], minutes, 2'h0, seconds}, 24'h030100);
        rd(8'h80, 4'h0, RTCST_RESP_SLVERR);
        wr(8'h80, 4'h0, RTCST_RESP_SLVERR);
        wt(2);
        final_report();
    end
endmodule
`default_nettype wire
